// >>> src/qsw_pkg.sv
package qsw_pkg;
	localparam int FRAME_BITS = 16;
	localparam int CNT_W = 4;
	localparam int WD_BIT = 15;
	localparam int CH_HI = 14;
	localparam int CH_LO = 13;
	localparam int ADDR_HI = 12;
	localparam int ADDR_LO = 10;
	localparam int PAYLOAD_W = 9;
	localparam int NUM_CH = 4;
	localparam logic [2:0] ADDR_STATUS = 3'h0;
	localparam logic [2:0] ADDR_DUTY = 3'h1;
	localparam logic [2:0] ADDR_SWITCH = 3'h2;
	localparam logic [2:0] ADDR_FAULT = 3'h3;
	localparam logic [2:0] ADDR_OCP = 3'h4;
	localparam logic [2:0] ADDR_GLOBAL = 3'h5;
	localparam logic [2:0] ADDR_CAL = 3'h7;
	localparam logic [8:0] REG_RESET = 9'h000;
	localparam int DUTY_ON_BIT = 7;
	localparam int SW_DIR_DIS_BIT = 5;
	localparam int FLT_RATIO_BIT = 0;
	localparam int GCR_SUPPLY_FAIL_EN_BIT = 8;
	localparam int GCR_TEMP_EN_BIT = 5;
	localparam int GCR_SENSE_EN_BIT = 4;
	localparam int GCR_SENSE_SEL_HI = 3;
	localparam int GCR_SENSE_SEL_LO = 2;
	localparam int GCR_OVERVOLTAGE_DISABLE_BIT = 0;
	localparam int SEL_CH_HI = 4;
	localparam int SEL_CH_LO = 3;
	localparam int SEL_KIND_HI = 2;
	localparam int SEL_KIND_LO = 0;
	localparam logic [1:0] SENSE_OFF = 2'h0;
	localparam logic [1:0] SENSE_CURRENT = 2'h1;
	localparam logic [1:0] SENSE_TEMP = 2'h2;
endpackage

// >>> src/qsw_regmem.sv
`timescale 1ns/1ps
`default_nettype none
module qsw_regmem (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_clear,
	input  wire logic       i_we,
	input  wire logic [3:0] i_waddr,
	input  wire logic [8:0] i_wdata,
	input  wire logic [3:0] i_raddr,
	output logic      [8:0] o_rdata
);
	logic [8:0] mem_r [16];

	// Storage with bulk clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < 16; i++) begin
				mem_r[i] <= qsw_pkg::REG_RESET;
			end
		end else if (i_clear) begin
			for (int i = 0; i < 16; i++) begin
				mem_r[i] <= qsw_pkg::REG_RESET;
			end
		end else if (i_we) begin
			mem_r[i_waddr] <= i_wdata;
		end
	end

	// Registered read
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= qsw_pkg::REG_RESET;
		end else begin
			o_rdata <= mem_r[i_raddr];
		end
	end
endmodule
`default_nettype wire

// >>> src/qsw_spi_regs.sv
// How it works
// - Frames are sixteen bits, shifted in most significant bit first
// - Bit 15 is the watchdog toggle; device tracks alternation
// - Bits 14:13 pick channel for per-channel registers
// - Bits 12:10 pick target register
// - Bits 8:0 are the register payload
// - Bit count not multiple of sixteen discards the frame
// - Transfer length multiple of sixteen accepted; only last frame applied, earlier bits passed on to SDO
// - Logic supply fail with enable set clears all registers
// - Without logic supply, inputs drive outputs; config treated zero
// - Power supply loss keeps configuration and status reporting
// - Power supply loss reported as undervoltage flag
// - Both supplies below reset level clear registers and faults
// - Prewarning flag sets and latches above threshold in normal mode
// - Prewarning clears after a read with temperature below threshold, or on supply reset or missing logic supply
// - Sense source follows temp enable, sense enable, select, ratio
// - Current mirror only while switch on; none in fail-safe
// - Clamp event forces all outputs on
// - Status request bits 4:3 channel, 2:0 content kind
// - Requested status returned in first sixteen bits of next frame
// - Channel code is binary, channel zero default
`timescale 1ns/1ps
`default_nettype none
module qsw_spi_regs (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_sclk,
	input  wire logic       i_cs_n,
	input  wire logic       i_sdi,
	input  wire logic [3:0] i_direct_in,
	input  wire logic       i_logic_supply_fail,
	input  wire logic       i_logic_supply_absent,
	input  wire logic       i_power_supply_lost,
	input  wire logic       i_supply_por,
	input  wire logic       i_temp_over_prewarn,
	input  wire logic       i_fail_safe,
	input  wire logic       i_clamp_event,
	output logic            o_sdo,
	output logic            o_sdo_oe,
	output logic [3:0]      o_switch_output,
	output logic [1:0]      o_sense_source,
	output logic [1:0]      o_sense_channel,
	output logic            o_sense_ratio,
	output logic            o_overvoltage_disable,
	output logic            o_watchdog_toggle,
	output logic            o_watchdog_ok,
	output logic            o_temperature_prewarning_flag,
	output logic            o_undervoltage_flag
);
	////////////////////////////////////////////////////////////////
	// Synchronisers
	logic [1:0] sclk_s_r, cs_s_r, sdi_s_r;
	logic [1:0] vdd_fail_s_r, vdd_abs_s_r, pwr_lost_s_r, por_s_r;
	logic [1:0] otw_s_r, fs_s_r, clamp_s_r;
	logic [1:0] din_s0_r, din_s1_r, din_s2_r, din_s3_r;
	logic       sclk_d_r;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sclk_s_r     <= 2'h0;
			cs_s_r       <= 2'h3;
			sdi_s_r      <= 2'h0;
			vdd_fail_s_r <= 2'h0;
			vdd_abs_s_r  <= 2'h0;
			pwr_lost_s_r <= 2'h0;
			por_s_r      <= 2'h0;
			otw_s_r      <= 2'h0;
			fs_s_r       <= 2'h0;
			clamp_s_r    <= 2'h0;
			din_s0_r     <= 2'h0;
			din_s1_r     <= 2'h0;
			din_s2_r     <= 2'h0;
			din_s3_r     <= 2'h0;
			sclk_d_r     <= 1'b0;
		end else begin
			sclk_s_r     <= {sclk_s_r[0], i_sclk};
			cs_s_r       <= {cs_s_r[0], i_cs_n};
			sdi_s_r      <= {sdi_s_r[0], i_sdi};
			vdd_fail_s_r <= {vdd_fail_s_r[0], i_logic_supply_fail};
			vdd_abs_s_r  <= {vdd_abs_s_r[0], i_logic_supply_absent};
			pwr_lost_s_r <= {pwr_lost_s_r[0], i_power_supply_lost};
			por_s_r      <= {por_s_r[0], i_supply_por};
			otw_s_r      <= {otw_s_r[0], i_temp_over_prewarn};
			fs_s_r       <= {fs_s_r[0], i_fail_safe};
			clamp_s_r    <= {clamp_s_r[0], i_clamp_event};
			din_s0_r     <= {din_s0_r[0], i_direct_in[0]};
			din_s1_r     <= {din_s1_r[0], i_direct_in[1]};
			din_s2_r     <= {din_s2_r[0], i_direct_in[2]};
			din_s3_r     <= {din_s3_r[0], i_direct_in[3]};
			sclk_d_r     <= sclk_s_r[1];
		end
	end

	logic       cs_act, sclk_rise, sclk_fall, cs_d_r;
	logic [3:0] din;
	assign cs_act    = ~cs_s_r[1];
	assign sclk_rise = sclk_s_r[1] & ~sclk_d_r;
	assign sclk_fall = ~sclk_s_r[1] & sclk_d_r;
	assign din       = {din_s3_r[1], din_s2_r[1], din_s1_r[1], din_s0_r[1]};

	////////////////////////////////////////////////////////////////
	// Frame assembly
	logic [15:0] shift_r;
	logic [3:0]  bit_cnt_r;
	logic        any_bits_r;
	logic        wrap_r;
	logic        frame_end;
	assign frame_end = cs_d_r & ~cs_act;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cs_d_r     <= 1'b0;
			shift_r    <= 16'h0000;
			bit_cnt_r  <= 4'h0;
			any_bits_r <= 1'b0;
			wrap_r     <= 1'b0;
		end else begin
			cs_d_r <= cs_act;
			if (cs_act && !cs_d_r) begin
				bit_cnt_r  <= 4'h0;
				any_bits_r <= 1'b0;
				wrap_r     <= 1'b0;
			end else if (cs_act && sclk_rise) begin
				shift_r    <= {shift_r[14:0], sdi_s_r[1]};
				bit_cnt_r  <= bit_cnt_r + 4'h1;
				any_bits_r <= 1'b1;
				if (bit_cnt_r == 4'hf) begin
					wrap_r <= 1'b1;
				end
			end
		end
	end

	logic frame_ok;
	assign frame_ok = frame_end && any_bits_r && (bit_cnt_r == 4'h0);

	logic [1:0] f_ch;
	logic [2:0] f_addr;
	logic [8:0] f_pay;
	assign f_ch   = shift_r[qsw_pkg::CH_HI:qsw_pkg::CH_LO];
	assign f_addr = shift_r[qsw_pkg::ADDR_HI:qsw_pkg::ADDR_LO];
	assign f_pay  = shift_r[qsw_pkg::PAYLOAD_W-1:0];

	////////////////////////////////////////////////////////////////
	// Register storage
	function automatic logic [3:0] reg_index(input logic [2:0] a, input logic [1:0] ch);
		logic [3:0] idx;
		idx = 4'h0;
		unique case (a)
			qsw_pkg::ADDR_DUTY:   idx = {2'h0, ch};
			qsw_pkg::ADDR_SWITCH: idx = {2'h1, ch};
			qsw_pkg::ADDR_FAULT:  idx = {2'h2, ch};
			qsw_pkg::ADDR_OCP:    idx = {2'h3, ch};
			default:              idx = 4'h0;
		endcase
		return idx;
	endfunction

	logic [8:0] gcr_r, cal_r, duty_on_r, dir_dis_r, ratio_r;
	logic       wipe, is_chan;
	logic [3:0] mem_waddr;
	logic       mem_we;
	assign wipe = (vdd_fail_s_r[1] & gcr_r[qsw_pkg::GCR_SUPPLY_FAIL_EN_BIT])
		| por_s_r[1] | vdd_abs_s_r[1];
	assign is_chan   = (f_addr >= qsw_pkg::ADDR_DUTY) && (f_addr <= qsw_pkg::ADDR_OCP);
	assign mem_we    = frame_ok && is_chan;
	assign mem_waddr = reg_index(f_addr, f_ch);

	logic [4:0] status_sel_r;
	logic [8:0] mem_rdata;
	logic [3:0] mem_raddr;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gcr_r        <= qsw_pkg::REG_RESET;
			cal_r        <= qsw_pkg::REG_RESET;
			status_sel_r <= 5'h00;
			duty_on_r    <= 9'h000;
			dir_dis_r    <= 9'h000;
			ratio_r      <= 9'h000;
		end else if (wipe) begin
			gcr_r        <= qsw_pkg::REG_RESET;
			cal_r        <= qsw_pkg::REG_RESET;
			status_sel_r <= 5'h00;
			duty_on_r    <= 9'h000;
			dir_dis_r    <= 9'h000;
			ratio_r      <= 9'h000;
		end else if (frame_ok) begin
			unique case (f_addr)
				qsw_pkg::ADDR_STATUS: status_sel_r <= f_pay[4:0];
				qsw_pkg::ADDR_GLOBAL: gcr_r <= f_pay;
				qsw_pkg::ADDR_CAL:    cal_r <= f_pay;
				qsw_pkg::ADDR_DUTY:   duty_on_r[f_ch] <= f_pay[qsw_pkg::DUTY_ON_BIT];
				qsw_pkg::ADDR_SWITCH: dir_dis_r[f_ch] <= f_pay[qsw_pkg::SW_DIR_DIS_BIT];
				qsw_pkg::ADDR_FAULT:  ratio_r[f_ch] <= f_pay[qsw_pkg::FLT_RATIO_BIT];
				default: ;
			endcase
		end
	end

	qsw_regmem u_mem (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_clear (wipe),
		.i_we    (mem_we),
		.i_waddr (mem_waddr),
		.i_wdata (f_pay),
		.i_raddr (mem_raddr),
		.o_rdata (mem_rdata)
	);

	assign mem_raddr = reg_index(status_sel_r[2:0],
		status_sel_r[qsw_pkg::SEL_CH_HI:qsw_pkg::SEL_CH_LO]);

	////////////////////////////////////////////////////////////////
	// Watchdog tracking
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_watchdog_toggle <= 1'b0;
			o_watchdog_ok     <= 1'b0;
		end else if (frame_ok) begin
			o_watchdog_toggle <= shift_r[qsw_pkg::WD_BIT];
			o_watchdog_ok     <= shift_r[qsw_pkg::WD_BIT] != o_watchdog_toggle;
		end
	end

	////////////////////////////////////////////////////////////////
	// Flags
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_temperature_prewarning_flag <= 1'b0;
			o_undervoltage_flag           <= 1'b0;
		end else if (por_s_r[1] || vdd_abs_s_r[1]) begin
			o_temperature_prewarning_flag <= 1'b0;
			o_undervoltage_flag           <= 1'b0;
		end else begin
			if (otw_s_r[1] && !fs_s_r[1]) begin
				o_temperature_prewarning_flag <= 1'b1;
			end else if (frame_ok && f_addr == qsw_pkg::ADDR_STATUS) begin
				o_temperature_prewarning_flag <= 1'b0;
			end
			if (pwr_lost_s_r[1]) begin
				o_undervoltage_flag <= 1'b1;
			end else if (frame_ok && f_addr == qsw_pkg::ADDR_STATUS) begin
				o_undervoltage_flag <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Status return
	logic [15:0] tx_r;
	logic [15:0] status_word;
	always_comb begin
		status_word = {o_watchdog_toggle, status_sel_r[4:3], 2'h0,
			o_undervoltage_flag, o_temperature_prewarning_flag, mem_rdata};
		if (status_sel_r[2:0] == qsw_pkg::ADDR_GLOBAL) begin
			status_word[8:0] = gcr_r;
		end else if (status_sel_r[2:0] == qsw_pkg::ADDR_CAL) begin
			status_word[8:0] = cal_r;
		end else if (status_sel_r[2:0] == qsw_pkg::ADDR_STATUS) begin
			status_word[8:0] = {4'h0, ~fs_s_r[1], din};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_r     <= 16'h0000;
			o_sdo    <= 1'b0;
			o_sdo_oe <= 1'b0;
		end else begin
			o_sdo_oe <= cs_act;
			if (cs_act && !cs_d_r) begin
				tx_r  <= {status_word[14:0], 1'b0};
				o_sdo <= status_word[15];
			end else if (cs_act && sclk_fall) begin
				tx_r  <= {tx_r[14:0], 1'b0};
				o_sdo <= wrap_r ? shift_r[15] : tx_r[15];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs and sense routing
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_switch_output       <= 4'h0;
			o_sense_source        <= qsw_pkg::SENSE_OFF;
			o_sense_channel       <= 2'h0;
			o_sense_ratio         <= 1'b0;
			o_overvoltage_disable <= 1'b0;
		end else begin
			if (clamp_s_r[1]) begin
				o_switch_output <= 4'hf;
			end else if (vdd_abs_s_r[1]) begin
				o_switch_output <= din;
			end else begin
				o_switch_output <= duty_on_r[3:0] | (din & ~dir_dis_r[3:0]);
			end
			o_sense_channel <= gcr_r[qsw_pkg::GCR_SENSE_SEL_HI:qsw_pkg::GCR_SENSE_SEL_LO];
			o_sense_ratio   <= ratio_r[gcr_r[qsw_pkg::GCR_SENSE_SEL_HI:qsw_pkg::GCR_SENSE_SEL_LO]];
			o_overvoltage_disable <= gcr_r[qsw_pkg::GCR_OVERVOLTAGE_DISABLE_BIT];
			if (gcr_r[qsw_pkg::GCR_TEMP_EN_BIT]) begin
				o_sense_source <= qsw_pkg::SENSE_TEMP;
			end else if (gcr_r[qsw_pkg::GCR_SENSE_EN_BIT] && !fs_s_r[1]
				&& o_switch_output[gcr_r[qsw_pkg::GCR_SENSE_SEL_HI:qsw_pkg::GCR_SENSE_SEL_LO]]) begin
				o_sense_source <= qsw_pkg::SENSE_CURRENT;
			end else begin
				o_sense_source <= qsw_pkg::SENSE_OFF;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/qsw_host.sv
`timescale 1ns/1ps
`default_nettype none
module qsw_host (
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_sdi,
	input  wire logic i_sdo
);
	logic [63:0] rx;

	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_sdi  = 1'b0;
		rx     = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Whole transfer, most significant bit first, up to 64 bits
	task automatic xfer(input logic [63:0] d, input int n);
		o_cs_n = 1'b0;
		#80;
		for (int i = n - 1; i >= 0; i--) begin
			o_sdi = d[i];
			#80;
			o_sclk = 1'b1;
			rx = {rx[62:0], i_sdo};
			#80;
			o_sclk = 1'b0;
		end
		#80;
		o_cs_n = 1'b1;
		// Released line shows the inverse
		o_sdi = ~o_sdi;
		#240;
	endtask
endmodule
`default_nettype wire

// >>> tb/qsw_spi_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module qsw_spi_regs_checker (
	input wire logic       i_clk, i_rst_n, i_sclk, i_cs_n, i_sdi,
	input wire logic [3:0] i_direct_in,
	input wire logic       i_logic_supply_fail, i_logic_supply_absent, i_power_supply_lost,
	input wire logic       i_supply_por, i_temp_over_prewarn, i_fail_safe, i_clamp_event,
	input wire logic       o_sdo, o_sdo_oe,
	input wire logic [3:0] o_switch_output,
	input wire logic [1:0] o_sense_source, o_sense_channel,
	input wire logic       o_sense_ratio, o_overvoltage_disable, o_watchdog_toggle,
	input wire logic       o_watchdog_ok, o_temperature_prewarning_flag, o_undervoltage_flag
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	////////////////////////////////////////////////////////////////////////////////
	sequence s_frame_open;
		(!i_cs_n && !i_supply_por && !i_logic_supply_absent && !i_logic_supply_fail)[*6];
	endsequence
	sequence s_uv_held;
		(i_power_supply_lost && !i_supply_por && !i_logic_supply_absent
			&& !i_logic_supply_fail)[*6];
	endsequence
	sequence s_hot_held;
		(i_temp_over_prewarn && !i_fail_safe && !i_supply_por && !i_logic_supply_absent
			&& !i_logic_supply_fail)[*6];
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	chk_cfg_frame_hold: assert property (s_frame_open |-> $stable(o_sense_channel)
		&& $stable(o_overvoltage_disable) && $stable(o_watchdog_toggle))
		else $error("config changed inside a frame");
	chk_uv_flag_set: assert property (s_uv_held |-> o_undervoltage_flag)
		else $error("undervoltage flag missing");
	chk_prewarn_set: assert property (s_hot_held |-> o_temperature_prewarning_flag)
		else $error("prewarning flag missing");
	chk_prewarn_hold: assert property ($fell(o_temperature_prewarning_flag)
		&& !i_supply_por && !i_logic_supply_absent && !i_logic_supply_fail
		|-> i_cs_n && $past(i_cs_n, 2))
		else $error("prewarning cleared without a read");
	chk_clamp_all_on: assert property (i_clamp_event [*6] |-> o_switch_output == 4'hf)
		else $error("clamp did not force outputs on");
	chk_por_wipe: assert property ((i_supply_por && !i_clamp_event && i_direct_in == 4'h0)[*6]
		|-> o_switch_output == 4'h0 && !o_temperature_prewarning_flag && !o_undervoltage_flag)
		else $error("supply reset left state behind");
	chk_absent_zero: assert property (i_logic_supply_absent [*6]
		|-> !o_overvoltage_disable && o_sense_source == qsw_pkg::SENSE_OFF)
		else $error("config active without logic supply");
	chk_sense_failsafe: assert property (i_fail_safe [*6]
		|-> o_sense_source != qsw_pkg::SENSE_CURRENT)
		else $error("current mirror in fail-safe");
	chk_sdo_release: assert property (i_cs_n [*6] |-> !o_sdo_oe)
		else $error("sdo driven while deselected");
	chk_sdo_drive: assert property ((!i_cs_n)[*6] |-> o_sdo_oe)
		else $error("sdo not driven while selected");
endmodule

bind qsw_spi_regs qsw_spi_regs_checker u_chk (.i_clk, .i_rst_n, .i_sclk, .i_cs_n, .i_sdi,
	.i_direct_in, .i_logic_supply_fail, .i_logic_supply_absent, .i_power_supply_lost,
	.i_supply_por, .i_temp_over_prewarn, .i_fail_safe, .i_clamp_event, .o_sdo, .o_sdo_oe,
	.o_switch_output, .o_sense_source, .o_sense_channel, .o_sense_ratio,
	.o_overvoltage_disable, .o_watchdog_toggle, .o_watchdog_ok,
	.o_temperature_prewarning_flag, .o_undervoltage_flag);
`default_nettype wire

// >>> tb/qsw_spi_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module qsw_spi_regs_bench;
	logic       i_clk, i_rst_n, i_sclk, i_cs_n, i_sdi, o_sdo, o_sdo_oe, i_logic_supply_fail;
	logic       i_logic_supply_absent, i_power_supply_lost, i_supply_por, i_temp_over_prewarn;
	logic       i_fail_safe, i_clamp_event, o_sense_ratio, o_overvoltage_disable, wd;
	logic       o_watchdog_toggle, o_watchdog_ok, o_temperature_prewarning_flag;
	logic       o_undervoltage_flag;
	logic [3:0] i_direct_in, o_switch_output;
	logic [1:0] o_sense_source, o_sense_channel;
	int         err_total, n_tests;
	int         bad[3] = '{15, 17, 31};

	qsw_host u_host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdi(i_sdi), .i_sdo(o_sdo));
	qsw_spi_regs uut (.i_clk, .i_rst_n, .i_sclk, .i_cs_n, .i_sdi, .i_direct_in,
		.i_logic_supply_fail, .i_logic_supply_absent, .i_power_supply_lost, .i_supply_por,
		.i_temp_over_prewarn, .i_fail_safe, .i_clamp_event, .o_sdo, .o_sdo_oe,
		.o_switch_output, .o_sense_source, .o_sense_channel, .o_sense_ratio,
		.o_overvoltage_disable, .o_watchdog_toggle, .o_watchdog_ok,
		.o_temperature_prewarning_flag, .o_undervoltage_flag);

	always #4 i_clk = ~i_clk;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] f(input logic w, input logic [1:0] c, input logic [2:0] a,
		input logic [8:0] p);
		return {w, c, a, 1'b0, p};
	endfunction
	task automatic hold(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic send(input logic [63:0] d, input int n);
		u_host.xfer(d, n);
		hold(12);
	endtask
	task automatic wr(input logic [1:0] c, input logic [2:0] a, input logic [8:0] p);
		wd = ~wd;
		send(64'(f(wd, c, a, p)), 16);
	endtask
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#600000;
		err_total++;
		test_done();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		i_rst_n = 1'b0;
		i_direct_in = 4'h0;
		{i_logic_supply_fail, i_logic_supply_absent, i_power_supply_lost} = 3'h0;
		{i_supply_por, i_temp_over_prewarn, i_fail_safe, i_clamp_event} = 4'h0;
		wd = 1'b0;
		err_total = 0;
		n_tests = 0;
		hold(20);
		i_rst_n = 1'b1;
		hold(5);
		`CHK({o_switch_output, o_sense_source, o_sense_channel, o_sdo_oe}, 9'h0)
		fin("reset");
		for (int c = 0; c < 4; c++) begin
			wr(c[1:0], qsw_pkg::ADDR_DUTY, 9'h080);
			`CHK(o_switch_output, 4'((1 << (c + 1)) - 1))
			`CHK({o_watchdog_toggle, o_watchdog_ok}, {wd, 1'b1})
		end
		for (int c = 0; c < 4; c++) if (c != 2) wr(c[1:0], qsw_pkg::ADDR_DUTY, 9'h000);
		`CHK(o_switch_output, 4'h4)
		send(64'(f(wd, 2'h2, qsw_pkg::ADDR_DUTY, 9'h080)), 16);
		`CHK(o_watchdog_ok, 1'b0)
		fin("duty");
		foreach (bad[i]) begin
			send(64'(f(~wd, 2'h2, qsw_pkg::ADDR_DUTY, 9'h000)), bad[i]);
			`CHK({o_switch_output, o_watchdog_toggle}, {4'h4, wd})
		end
		fin("length");
		wd = ~wd;
		send({32'h0, f(~wd, 2'h0, qsw_pkg::ADDR_DUTY, 9'h080),
			f(wd, 2'h2, qsw_pkg::ADDR_DUTY, 9'h000)}, 32);
		`CHK({o_switch_output, o_watchdog_ok}, 5'h01)
		`CHK(u_host.rx[15:0], f(~wd, 2'h0, qsw_pkg::ADDR_DUTY, 9'h080))
		wr(2'h2, qsw_pkg::ADDR_DUTY, 9'h080);
		fin("daisy");
		wr(2'h2, qsw_pkg::ADDR_FAULT, 9'h001);
		wr(2'h0, qsw_pkg::ADDR_GLOBAL, 9'h019);
		`CHK({o_sense_source, o_sense_channel, o_sense_ratio, o_overvoltage_disable},
			{qsw_pkg::SENSE_CURRENT, 2'h2, 1'b1, 1'b1})
		i_fail_safe = 1'b1;
		hold(12);
		`CHK(o_sense_source, qsw_pkg::SENSE_OFF)
		i_fail_safe = 1'b0;
		wr(2'h2, qsw_pkg::ADDR_DUTY, 9'h000);
		`CHK(o_sense_source, qsw_pkg::SENSE_OFF)
		wr(2'h2, qsw_pkg::ADDR_DUTY, 9'h080);
		wr(2'h0, qsw_pkg::ADDR_GLOBAL, 9'h039);
		`CHK(o_sense_source, qsw_pkg::SENSE_TEMP)
		wr(2'h0, qsw_pkg::ADDR_STATUS, {4'h0, 2'h1, qsw_pkg::ADDR_GLOBAL});
		wr(2'h2, qsw_pkg::ADDR_DUTY, 9'h080);
		`CHK(u_host.rx[15:0], {~wd, 2'h1, 4'h0, 9'h039})
		fin("sense");
		i_clamp_event = 1'b1;
		hold(12);
		`CHK(o_switch_output, 4'hf)
		i_clamp_event = 1'b0;
		i_temp_over_prewarn = 1'b1;
		hold(12);
		`CHK(o_temperature_prewarning_flag, 1'b1)
		i_temp_over_prewarn = 1'b0;
		wr(2'h0, qsw_pkg::ADDR_DUTY, 9'h000);
		`CHK({o_switch_output, o_temperature_prewarning_flag}, 5'h09)
		wr(2'h0, qsw_pkg::ADDR_STATUS, 9'h000);
		`CHK(o_temperature_prewarning_flag, 1'b0)
		fin("flags");
		i_power_supply_lost = 1'b1;
		hold(12);
		`CHK({o_undervoltage_flag, o_sense_channel}, 3'h6)
		i_power_supply_lost = 1'b0;
		i_logic_supply_fail = 1'b1;
		hold(12);
		`CHK(o_sense_channel, 2'h2)
		i_logic_supply_fail = 1'b0;
		wr(2'h0, qsw_pkg::ADDR_GLOBAL, 9'h119);
		i_logic_supply_fail = 1'b1;
		hold(12);
		`CHK({o_switch_output, o_sense_channel, o_overvoltage_disable}, 7'h0)
		i_logic_supply_fail = 1'b0;
		wr(2'h0, qsw_pkg::ADDR_GLOBAL, 9'h001);
		i_logic_supply_absent = 1'b1;
		i_direct_in = 4'h5;
		hold(12);
		`CHK({o_switch_output, o_overvoltage_disable}, 5'h0a)
		i_logic_supply_absent = 1'b0;
		i_direct_in = 4'h0;
		fin("supply");
		wr(2'h2, qsw_pkg::ADDR_DUTY, 9'h080);
		i_temp_over_prewarn = 1'b1;
		hold(12);
		i_supply_por = 1'b1;
		i_temp_over_prewarn = 1'b0;
		hold(12);
		`CHK({o_switch_output, o_temperature_prewarning_flag, o_undervoltage_flag}, 6'h0)
		i_supply_por = 1'b0;
		fin("por");
		test_done();
	end
endmodule
`default_nettype wire
